// [sim/wcas_rtc_asserts.sv]
// concurrent checks on the watch clock block ports
`timescale 1ns/1ps
module wcas_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic set_time_load,
    input wire wcas_pkg::wcas_time_s set_time_value,
    input wire logic [wcas_pkg::NFLAG-1:0] flag_en,
    input wire logic [wcas_pkg::NFLAG-1:0] flag_clear,
    input wire logic sw_load,
    input wire logic [wcas_pkg::SW_W-1:0] sw_value,
    input wire wcas_pkg::wcas_time_s cur_time,
    input wire logic [wcas_pkg::SW_W-1:0] sw_count,
    input wire logic [wcas_pkg::NFLAG-1:0] flags,
    input wire logic irq,
    input wire logic wake_sleep,
    input wire logic wake_deep_sleep,
    input wire logic wake_hibernate
);
    import wcas_pkg::*;
    // ====
    // properties; all in one domain, quiet in reset
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_irq_or: assert property (irq == |flags)
        else $error("irq differs from flag or");
    a_wake_same: assert property (wake_sleep == wake_deep_sleep && wake_sleep == wake_hibernate)
        else $error("wake outputs differ");
    a_wake_irq: assert property (wake_sleep |-> irq)
        else $error("wake without flag");
    a_flag_sticky: assert property ((($past(flags) & ~$past(flag_clear)) & ~flags) == '0)
        else $error("flag dropped without clear");
    a_flag_gate: assert property ((flags & ~$past(flags) & ~$past(flag_en)) == '0)
        else $error("flag set while disabled");
    a_time_load: assert property (set_time_load |=> cur_time == $past(set_time_value))
        else $error("time load lost");
    a_sec_step: assert property ((!$past(set_time_load) && cur_time != $past(cur_time)) |->
        cur_time.sec == ($past(cur_time.sec) == SEC_MAX ? 6'h00 : $past(cur_time.sec) + 6'h01))
        else $error("seconds step wrong");
    a_sec_flag: assert property ((!$past(set_time_load) && cur_time != $past(cur_time)
        && $past(flag_en[FLG_SEC])) |-> flags[FLG_SEC])
        else $error("second flag missing");
    a_sw_load: assert property (sw_load |=> sw_count == $past(sw_value))
        else $error("stopwatch load lost");
    a_sw_step: assert property ((!$past(sw_load) && sw_count != $past(sw_count)) |->
        sw_count == $past(sw_count) - 16'h0001)
        else $error("stopwatch step wrong");
endmodule // wcas_chk
bind wcas_rtc wcas_chk wcas_chk_i (.core_clk, .rst_b, .set_time_load, .set_time_value, .flag_en,
    .flag_clear, .sw_load, .sw_value, .cur_time, .sw_count, .flags, .irq, .wake_sleep,
    .wake_deep_sleep, .wake_hibernate);

// [sim/wcas_tb.sv]
// self-checking bench for the watch clock block
`timescale 1ns/1ps
module testbench;
    import wcas_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, xtal_clk = 1'b0, set_time_load = 1'b0;
    wcas_time_s set_time_value = '0, alarm0_value = '0, alarm1_value = '0, cur_time;
    logic [NFLAG-1:0] flag_en = '1, wake_en = '0, flag_clear = '0, flags, m_flg = '0;
    logic sw_load = 1'b0, sw_enable = 1'b0, irq, wake_sleep, wake_deep_sleep, wake_hibernate;
    logic [SW_W-1:0] sw_value = '0, sw_count;
    logic [31:0] seed = 32'h0000_141e;
    int num_errors = 0, total_checks = 0, cycles = 0;
    int m_sec = 0, m_min = 0, m_hour = 0, m_day = 0, m_sw = 0, m_arm = 0; // model state
    // ====
    // clock, timeout, design
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            num_errors++;
            test_done();
        end
    end
    // short prescale keeps every second to eight core cycles
    wcas_rtc #(.PRESCALE_DIV(4)) wcas_rtc_i (.core_clk, .rst_b, .xtal_clk, .set_time_load,
        .set_time_value, .alarm0_value, .alarm1_value, .flag_en, .wake_en, .flag_clear, .sw_load,
        .sw_value, .sw_enable, .cur_time, .sw_count, .flags, .irq, .wake_sleep, .wake_deep_sleep,
        .wake_hibernate);
    // ====
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic cmp_time(input wcas_time_s exp, input wcas_time_s got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch cur_time exp %h got %h", exp, got);
        end
    endtask
    task automatic check_all();
        cmp_time({m_day[14:0], m_hour[4:0], m_min[5:0], m_sec[5:0]}, cur_time);
        cmp_val("sw_count", m_sw[15:0], sw_count);
        cmp_val("flags", 16'(m_flg), 16'(flags));
        cmp_val("irq", 16'(|m_flg), 16'(irq));
        cmp_val("wake", 16'({3{|(m_flg & wake_en)}}), 16'({wake_sleep, wake_deep_sleep, wake_hibernate}));
    endtask
    task automatic load(input wcas_time_s t, input logic [15:0] sw);
        @(posedge core_clk);
        set_time_value <= t;
        sw_value <= sw;
        set_time_load <= 1'b1;
        sw_load <= 1'b1;
        @(posedge core_clk);
        set_time_load <= 1'b0;
        sw_load <= 1'b0;
        m_day = int'(t.day);
        m_hour = int'(t.hour);
        m_min = int'(t.min);
        m_sec = int'(t.sec);
        m_sw = int'(sw);
        m_arm = 1;
        #1 check_all();
    endtask
    // four crystal rises make one second, then the model steps
    task automatic one_sec();
        logic [NFLAG-1:0] ev;
        repeat (4) begin
            @(posedge core_clk);
            xtal_clk <= 1'b1;
            @(posedge core_clk);
            xtal_clk <= 1'b0;
        end
        repeat (5) @(posedge core_clk);
        #1;
        ev = 7'h01;
        ev[FLG_MIN] = (m_sec == 59);
        m_sec = (m_sec + 1) % 60;
        ev[FLG_HOUR] = ev[FLG_MIN] && m_min == 59;
        if (ev[FLG_MIN]) m_min = (m_min + 1) % 60;
        ev[FLG_DAY] = ev[FLG_HOUR] && m_hour == 23;
        if (ev[FLG_HOUR]) m_hour = (m_hour + 1) % 24;
        if (ev[FLG_DAY]) m_day = (m_day + 1) % 32768;
        ev[FLG_ALM0] = {m_hour[4:0], m_min[5:0], m_sec[5:0]} === alarm0_value[16:0];
        ev[FLG_ALM1] = {m_day[14:0], m_hour[4:0], m_min[5:0], m_sec[5:0]} === alarm1_value;
        if (sw_enable && m_arm != 0) begin
            ev[FLG_SWU] = (m_sw == 0);
            if (m_sw == 0) m_arm = 0;
            else m_sw--;
        end
        m_flg = m_flg | (ev & flag_en);
        check_all();
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ====
    // main sequence: wrap of all counters, alarms, stopwatch, clear and gating
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        #1 check_all();
        @(posedge core_clk);
        seed = lfsr(seed);
        wake_en <= seed[6:0];
        alarm0_value <= {seed[14:0], 17'h0_0000};
        alarm1_value <= 32'h0000_0001;
        sw_enable <= 1'b1;
        load({DAY_MAX, HOUR_MAX, MIN_MAX, 6'h3a}, 16'h0002);
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk);
            // the second clear leaves the per-second flag low to show its gating
            if (i == 2 || i == 3) begin
                @(posedge core_clk);
                flag_clear <= '1;
                @(posedge core_clk);
                flag_clear <= '0;
                m_flg = '0;
            end
            if (i == 3) flag_en <= 7'h7e;
            if (i == 4) begin
                seed = lfsr(seed);
                sw_enable <= 1'b0;
                load({seed[14:0], 17'h0_bb7b}, seed[31:16]);
            end
            if (i == 5) sw_enable <= 1'b1;
            one_sec();
        end
        test_done();
    end
endmodule // testbench

// [verilog/wcas_pkg.sv]
// shared constants and types of the watch clock, alarm and stopwatch block
package wcas_pkg;

    // ==========================================
    // field widths
    localparam int SEC_W = 6;    // seconds field width
    localparam int MIN_W = 6;    // minutes field width
    localparam int HOUR_W = 5;   // hours field width
    localparam int DAY_W = 15;   // day field width, 32,768 days
    localparam int SW_W = 16;    // stopwatch countdown width
    localparam int PRESC_W = 15; // prescaler counter width

    // ==========================================
    // counter limits
    localparam logic [SEC_W-1:0] SEC_MAX = 6'h3B;        // 59
    localparam logic [MIN_W-1:0] MIN_MAX = 6'h3B;        // 59
    localparam logic [HOUR_W-1:0] HOUR_MAX = 5'h17;      // 23
    localparam logic [DAY_W-1:0] DAY_MAX = 15'h7FFF;     // 32767

    // ==========================================
    // timing: crystal edges per one-second tick
    localparam real XTAL_HZ = 32768.0;                   // crystal rate, hz
    localparam real TICK_HZ = 1.0;                       // tick rate, hz
    localparam int PRESCALE_DIV_DEF = int'(XTAL_HZ / TICK_HZ);

    // ==========================================
    // event flag positions
    localparam int FLG_SEC = 0;   // every second tick
    localparam int FLG_MIN = 1;   // seconds rolled over
    localparam int FLG_HOUR = 2;  // minutes rolled over
    localparam int FLG_DAY = 3;   // hours rolled over
    localparam int FLG_ALM0 = 4;  // time-of-day alarm
    localparam int FLG_ALM1 = 5;  // day and time alarm
    localparam int FLG_SWU = 6;   // stopwatch underflow
    localparam int NFLAG = 7;     // number of event flags

    // ==========================================
    // reset values
    localparam logic [NFLAG-1:0] FLAGS_RST = 7'h00;
    localparam logic [SW_W-1:0] SW_RST = 16'h0000;
    localparam logic [PRESC_W-1:0] PRESC_RST = 15'h0000;

    // time of day plus day count
    typedef struct packed {
        logic [DAY_W-1:0] day;
        logic [HOUR_W-1:0] hour;
        logic [MIN_W-1:0] min;
        logic [SEC_W-1:0] sec;
    } wcas_time_s;

    localparam wcas_time_s TIME_RST = '0;

endpackage

// [verilog/wcas_prescaler.sv]
// prescaler that turns crystal edges into a one-second tick
`timescale 1ns/1ps
module wcas_prescaler #(
    parameter int DIV = wcas_pkg::PRESCALE_DIV_DEF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic xtal_clk,
    input wire logic restart,
    output logic tick
);
    import wcas_pkg::*;

    // last count before the tick
    localparam logic [PRESC_W-1:0] LAST = PRESC_W'(DIV - 1);

    logic xtal_q; // previous crystal level, for edge detect
    logic [PRESC_W-1:0] cnt; // crystal edges seen this second
    logic next_tick;
    logic [PRESC_W-1:0] next_cnt;
    logic xtal_rise;

    // ==========================================
    // next count
    // the crystal level is synchronous, so it is edge detected directly
    always_comb begin
        xtal_rise = xtal_clk & ~xtal_q;
        next_cnt = cnt;
        next_tick = 1'b0;
        if (restart) begin
            // a new time restarts the second from zero
            next_cnt = PRESC_RST;
        end else if (xtal_rise) begin
            if (cnt == LAST) begin
                next_cnt = PRESC_RST;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 15'h0001;
            end
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            xtal_q <= 1'b0;
            cnt <= PRESC_RST;
            tick <= 1'b0;
        end else begin
            xtal_q <= xtal_clk;
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule // wcas_prescaler

// [verilog/wcas_rtc.sv]
// watch clock with two alarms, stopwatch countdown and wakeup events
// What this block does
// - prescaler divides crystal down to one hertz tick
// - cascade seconds, minutes, hours and 32768 days
// - enabled alarm match raises an event flag
// - alarm zero time only, alarm one day too
// - stopwatch loads value, decrements every second
// - stopwatch underflow raises event while enabled
// - selectable per second, minute, hour, day events
// - any enabled event wakes processor from sleep
// - events also wake deep sleep, exit hibernate
`timescale 1ns/1ps
module wcas_rtc #(
    parameter int PRESCALE_DIV = wcas_pkg::PRESCALE_DIV_DEF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic xtal_clk,
    input wire logic set_time_load,
    input wire wcas_pkg::wcas_time_s set_time_value,
    input wire wcas_pkg::wcas_time_s alarm0_value,
    input wire wcas_pkg::wcas_time_s alarm1_value,
    input wire logic [wcas_pkg::NFLAG-1:0] flag_en,
    input wire logic [wcas_pkg::NFLAG-1:0] wake_en,
    input wire logic [wcas_pkg::NFLAG-1:0] flag_clear,
    input wire logic sw_load,
    input wire logic [wcas_pkg::SW_W-1:0] sw_value,
    input wire logic sw_enable,
    output wcas_pkg::wcas_time_s cur_time,
    output logic [wcas_pkg::SW_W-1:0] sw_count,
    output logic [wcas_pkg::NFLAG-1:0] flags,
    output logic irq,
    output logic wake_sleep,
    output logic wake_deep_sleep,
    output logic wake_hibernate
);
    import wcas_pkg::*;

    // ==========================================
    // timing overview
    // cycle t: the prescaler tick is high for one cycle
    // edge ending t: time, stopwatch, periodic flags and irq update
    // cycle t+1: tick_d is high and the alarms compare the new time
    // edge ending t+1: alarm flags and their irq and wake update
    // the extra cycle costs one core clock of alarm latency, which is
    // nothing against a one-second tick, and keeps the alarm compare
    // off the carry chain of the cascaded counters
    // a time load in cycle t swallows that tick for the time group, so
    // no per-second flag and no alarm of the old second leaks into the
    // freshly loaded time

    // ==========================================
    // declarations
    logic tick;               // one-cycle pulse per second
    logic tick_d;             // tick delayed until counters have settled
    logic next_tick_d;        // tick that survived a time load
    wcas_time_s next_time;    // time after this cycle
    logic sec_roll;           // seconds wrapped 59 to 0
    logic min_roll;           // minutes wrapped 59 to 0
    logic hour_roll;          // hours wrapped 23 to 0
    logic sw_armed;           // countdown still to underflow
    logic [SW_W-1:0] next_sw_count; // countdown after this cycle
    logic next_sw_armed;            // arming after this cycle
    logic sw_under;           // underflow seen this cycle
    logic [NFLAG-1:0] events; // raw events before gating
    logic [NFLAG-1:0] next_flags; // sticky flags after this cycle
    logic next_irq;               // or of the next flags
    logic next_wake;              // or of the next wake-enabled flags
    logic wake;               // shared wake request, from a flop

    // ==========================================
    // one-second tick source
    // the prescaler restarts on a time load, so the first second after
    // a load is a full second long
    wcas_prescaler #(
        .DIV(PRESCALE_DIV)
    ) u_prescaler (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .xtal_clk(xtal_clk),
        .restart(set_time_load),
        .tick(tick)
    );

    // ==========================================
    // time counters
    // software load wins over a tick in the same cycle; loaded values
    // are taken as legal, an out-of-range field only wraps at its maximum
    // each field only moves when every field below it wraps in the
    // same tick, so the cascade needs one small adder per field
    always_comb begin
        next_time = cur_time;
        // a tick under a load is dropped so the alarms skip that second
        next_tick_d = tick & ~set_time_load;
        sec_roll = 1'b0;
        min_roll = 1'b0;
        hour_roll = 1'b0;
        if (set_time_load) begin
            // direct load of the whole time
            next_time = set_time_value;
        end else if (tick) begin
            if (cur_time.sec == SEC_MAX) begin
                next_time.sec = '0;
                sec_roll = 1'b1;
            end else begin
                next_time.sec = cur_time.sec + 6'h01;
            end
            if (sec_roll) begin
                if (cur_time.min == MIN_MAX) begin
                    next_time.min = '0;
                    min_roll = 1'b1;
                end else begin
                    next_time.min = cur_time.min + 6'h01;
                end
            end
            if (min_roll) begin
                if (cur_time.hour == HOUR_MAX) begin
                    next_time.hour = '0;
                    hour_roll = 1'b1;
                end else begin
                    next_time.hour = cur_time.hour + 5'h01;
                end
            end
            if (hour_roll) begin
                if (cur_time.day == DAY_MAX) begin
                    next_time.day = '0;
                end else begin
                    next_time.day = cur_time.day + 15'h0001;
                end
            end
        end
    end

    // ==========================================
    // stopwatch countdown
    // the underflow fires once per load; after it the count rests at
    // zero so a forgotten stopwatch does not flood the flag
    // a stopped stopwatch keeps its count and its arming; enabling it
    // again resumes the countdown where it was
    always_comb begin
        next_sw_count = sw_count;
        next_sw_armed = sw_armed;
        sw_under = 1'b0;
        if (sw_load) begin
            // reload and rearm
            next_sw_count = sw_value;
            next_sw_armed = 1'b1;
        end else if (tick && sw_enable && sw_armed) begin
            if (sw_count == SW_RST) begin
                // counting below zero is the underflow
                sw_under = 1'b1;
                next_sw_armed = 1'b0;
            end else begin
                next_sw_count = sw_count - 16'h0001;
            end
        end
    end

    // ==========================================
    // event sources
    // alarms look at tick_d, one cycle after the tick, so they compare
    // against the already updated counters
    // the rollover events come straight from the counter carries, so a
    // loaded time never raises them
    always_comb begin
        events = '0;
        // the per-second event follows the time, so a loaded tick drops it
        events[FLG_SEC] = tick & ~set_time_load;
        events[FLG_MIN] = sec_roll;
        events[FLG_HOUR] = min_roll;
        events[FLG_DAY] = hour_roll;
        // time of day only, matches every day
        events[FLG_ALM0] = tick_d && (cur_time.hour == alarm0_value.hour)
                           && (cur_time.min == alarm0_value.min)
                           && (cur_time.sec == alarm0_value.sec);
        // day and time of that day
        events[FLG_ALM1] = tick_d && (cur_time == alarm1_value);
        events[FLG_SWU] = sw_under;
    end

    // ==========================================
    // sticky flags and wake requests
    // a new event in the clear cycle keeps its flag set
    // irq and wake are registered from the next flags, so they change on
    // the same edge as the flags themselves and never glitch
    always_comb begin
        next_flags = (flags & ~flag_clear) | (events & flag_en);
        next_irq = |next_flags;
        next_wake = |(next_flags & wake_en);
    end

    // ==========================================
    // registers
    // one register process for the block outside the prescaler; every next value comes
    // from the processes above
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_time <= TIME_RST;
            tick_d <= 1'b0;
            sw_count <= SW_RST;
            sw_armed <= 1'b0;
            flags <= FLAGS_RST;
            irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            cur_time <= next_time;
            tick_d <= next_tick_d;
            sw_count <= next_sw_count;
            sw_armed <= next_sw_armed;
            flags <= next_flags;
            irq <= next_irq;
            wake <= next_wake;
        end
    end

    // ==========================================
    // wake outputs
    // one request serves all three low-power exits; the power manager
    // picks the one that matches the state it is in
    // the request is a level; it stays high until software clears every
    // flag that has its wake enable set
    assign wake_sleep = wake;
    assign wake_deep_sleep = wake;
    assign wake_hibernate = wake;

endmodule // wcas_rtc
